// *** core/cps_pkg.sv ***
package cps_pkg;
  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int          CPS_IDX_W        = 4;
  localparam int          CPS_DIV_W        = 8;
  localparam int          CPS_PAR_W        = 32;
  localparam int          CPS_NPAR         = 4;
  localparam logic [3:0]  CPS_FIRST_SET    = 4'h1;
  localparam logic [7:0]  CPS_DIV_RST      = 8'h00;

  // ----------------------------------------------------------------
  // Modes and selections
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {CPS_MODE_OFF, CPS_MODE_ACTIVE} cps_mode_e;

  typedef enum logic [3:0] {
    CPS_SRC_NONE, CPS_SRC_IN1, CPS_SRC_IN2, CPS_SRC_IN3, CPS_SRC_IN4,
    CPS_SRC_CNT1, CPS_SRC_CNT2, CPS_SRC_TMR1, CPS_SRC_TMR2,
    CPS_SRC_FRAME_TRIG, CPS_SRC_FRAME_END, CPS_SRC_EXPO_START,
    CPS_SRC_ACQ_START, CPS_SRC_SOFTWARE
  } cps_src_e;

  typedef enum logic [0:0] {CPS_SYNC_LINE, CPS_SYNC_FRAME} cps_sync_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ext_input_one;
    logic ext_input_two;
    logic ext_input_three;
    logic ext_input_four;
    logic count_unit_one_done;
    logic count_unit_two_done;
    logic delay_unit_one_done;
    logic delay_unit_two_done;
    logic accepted_frame_trigger;
    logic frame_end;
    logic exposure_start;
    logic acquisition_start;
  } cps_events_s;

  typedef struct packed {
    cps_mode_e             sequencer_mode_select;
    logic [CPS_IDX_W-1:0]  set_count;
    cps_src_e              advance_source_select;
    logic [CPS_DIV_W-1:0]  advance_event_divider;
    cps_src_e              index_clear_source;
    cps_sync_e             apply_sync_point;
  } cps_cfg_s;
endpackage : cps_pkg

// *** core/cps_param_ram.sv ***
`timescale 1ns/1ps
module cps_param_ram #(
  parameter int DEPTH = 16,
  parameter int AW    = 4,
  parameter int W     = 32
) (
  input  wire logic          sys_clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data
);
  logic [W-1:0] mem [DEPTH];

  initial begin
    if (DEPTH > (1 << AW)) $error("Depth exceeds address range");
  end

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : cps_param_ram

// *** core/cps_sequencer.sv ***
// What this block does
// - Mode Off disables cycling entirely; mode Active enables automatic set switching.
// - The sequence length is the programmed set count; a set count of 0 gives one set.
// - Index advances on the selected source; four external inputs are selectable.
// - Source None never advances; software-written index selects the active set.
// - Either counter end event may be selected as advance source.
// - Either timer end event may be selected as advance source.
// - Each accepted frame trigger may be selected as advance source.
// - While enabled, switching happens in hardware with no software per switch.
// - A switch updates only parameters flagged to change; others stay untouched.
// - The divider number of events is needed before the index advances once.
// - An event from the selected clear source sets the index back to 1.
// - The software clear command returns index to 1 and event count to 0.
// - In mode Active a new set applies only at the next line or frame start, as configured; in mode Off a written index applies at once.
`timescale 1ns/1ps
module cps_sequencer #(
  parameter int IDX_W = cps_pkg::CPS_IDX_W,
  parameter int DIV_W = cps_pkg::CPS_DIV_W,
  parameter int PAR_W = cps_pkg::CPS_PAR_W,
  parameter int NPAR  = cps_pkg::CPS_NPAR
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire cps_pkg::cps_cfg_s        cfg,
  input  wire cps_pkg::cps_events_s     events,
  input  wire logic                     index_clear_command,
  input  wire logic                     manual_set_write,
  input  wire logic [IDX_W-1:0]         manual_set_index,
  input  wire logic [NPAR-1:0]          param_change_mask,
  input  wire logic                     set_table_write,
  input  wire logic [IDX_W-1:0]         set_table_addr,
  input  wire logic [NPAR*PAR_W-1:0]    set_table_data,
  input  wire logic                     line_start,
  input  wire logic                     frame_start,
  output logic      [IDX_W-1:0]         active_set_index,
  output logic      [NPAR*PAR_W-1:0]    active_params,
  output logic      [NPAR-1:0]          param_updated
);
  initial begin
    if (IDX_W != cps_pkg::CPS_IDX_W) $error("IDX_W must match package");
    if (DIV_W != cps_pkg::CPS_DIV_W) $error("DIV_W must match package");
    if (NPAR < 1) $error("NPAR must be at least one");
  end

  // ----------------------------------------------------------------
  // Event selection
  // ----------------------------------------------------------------
  function automatic logic pick(input cps_pkg::cps_src_e s, input cps_pkg::cps_events_s e,
                                input logic sw);
    logic r;
    r = 1'b0;
    case (s)
      cps_pkg::CPS_SRC_IN1:        r = e.ext_input_one;
      cps_pkg::CPS_SRC_IN2:        r = e.ext_input_two;
      cps_pkg::CPS_SRC_IN3:        r = e.ext_input_three;
      cps_pkg::CPS_SRC_IN4:        r = e.ext_input_four;
      cps_pkg::CPS_SRC_CNT1:       r = e.count_unit_one_done;
      cps_pkg::CPS_SRC_CNT2:       r = e.count_unit_two_done;
      cps_pkg::CPS_SRC_TMR1:       r = e.delay_unit_one_done;
      cps_pkg::CPS_SRC_TMR2:       r = e.delay_unit_two_done;
      cps_pkg::CPS_SRC_FRAME_TRIG: r = e.accepted_frame_trigger;
      cps_pkg::CPS_SRC_FRAME_END:  r = e.frame_end;
      cps_pkg::CPS_SRC_EXPO_START: r = e.exposure_start;
      cps_pkg::CPS_SRC_ACQ_START:  r = e.acquisition_start;
      cps_pkg::CPS_SRC_SOFTWARE:   r = sw;
      default:                     r = 1'b0;
    endcase
    return r;
  endfunction : pick

  logic active_mode;
  logic adv_evt;
  logic clr_evt;
  logic sync_evt;

  always_comb begin
    active_mode = (cfg.sequencer_mode_select == cps_pkg::CPS_MODE_ACTIVE);
    adv_evt     = active_mode && pick(cfg.advance_source_select, events, 1'b0);
    clr_evt     = active_mode && pick(cfg.index_clear_source, events,
                                      index_clear_command);
    sync_evt    = (cfg.apply_sync_point == cps_pkg::CPS_SYNC_LINE) ? line_start
                                                                     : frame_start;
  end

  // ----------------------------------------------------------------
  // Position counter
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] evt_cnt_reg,  evt_cnt_next;
  logic [IDX_W-1:0] pend_idx_reg, pend_idx_next;
  logic             pend_reg,     pend_next;
  logic [IDX_W-1:0] act_idx_reg,  act_idx_next;
  logic [IDX_W-1:0] last_set;
  logic             div_hit;

  always_comb begin
    last_set      = (cfg.set_count == '0) ? cps_pkg::CPS_FIRST_SET : cfg.set_count;
    // Divider 0 or 1 both mean every event advances
    div_hit       = (evt_cnt_reg + 1'b1 >= cfg.advance_event_divider);
    evt_cnt_next  = evt_cnt_reg;
    pend_idx_next = pend_idx_reg;
    pend_next     = pend_reg;
    act_idx_next  = act_idx_reg;
    if (!active_mode) begin
      evt_cnt_next = cps_pkg::CPS_DIV_RST;
      pend_next    = 1'b0;
      if (manual_set_write) begin
        act_idx_next  = manual_set_index;
        pend_idx_next = manual_set_index;
      end
    end else if (index_clear_command || clr_evt) begin
      evt_cnt_next  = cps_pkg::CPS_DIV_RST;
      pend_idx_next = cps_pkg::CPS_FIRST_SET;
      pend_next     = 1'b1;
    end else begin
      if (cfg.advance_source_select == cps_pkg::CPS_SRC_NONE) begin
        if (manual_set_write) begin
          pend_idx_next = manual_set_index;
          pend_next     = 1'b1;
        end
      end else if (adv_evt) begin
        if (div_hit) begin
          evt_cnt_next  = cps_pkg::CPS_DIV_RST;
          pend_idx_next = (pend_idx_reg >= last_set) ? cps_pkg::CPS_FIRST_SET
                                                     : IDX_W'(pend_idx_reg + 1'b1);
          pend_next     = 1'b1;
        end else begin
          evt_cnt_next = DIV_W'(evt_cnt_reg + 1'b1);
        end
      end
      if (pend_reg && sync_evt) begin
        act_idx_next = pend_idx_reg;
        if (!(adv_evt && div_hit) && !manual_set_write) begin
          pend_next = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      evt_cnt_reg  <= cps_pkg::CPS_DIV_RST;
      pend_idx_reg <= cps_pkg::CPS_FIRST_SET;
      pend_reg     <= 1'b0;
      act_idx_reg  <= cps_pkg::CPS_FIRST_SET;
    end else begin
      evt_cnt_reg  <= evt_cnt_next;
      pend_idx_reg <= pend_idx_next;
      pend_reg     <= pend_next;
      act_idx_reg  <= act_idx_next;
    end
  end

  // ----------------------------------------------------------------
  // Parameter sets and selective update
  // ----------------------------------------------------------------
  logic [NPAR*PAR_W-1:0] table_rd;
  logic                  load_reg, load_next;
  logic [NPAR*PAR_W-1:0] params_reg, params_next;
  logic [NPAR-1:0]       upd_reg,    upd_next;
  logic [IDX_W-1:0]      idx_out_reg;

  cps_param_ram #(
    .DEPTH (1 << IDX_W),
    .AW    (IDX_W),
    .W     (NPAR*PAR_W)
  ) u_ram (
    .sys_clk (sys_clk),
    .wr_en   (set_table_write),
    .wr_addr (set_table_addr),
    .wr_data (set_table_data),
    .rd_addr (act_idx_reg),
    .rd_data (table_rd)
  );

  always_comb begin
    // RAM read is registered, so wait until it has seen the new index
    load_next   = (act_idx_reg != idx_out_reg);
    params_next = params_reg;
    upd_next    = '0;
    if (load_reg) begin
      for (int i = 0; i < NPAR; i++) begin
        if (param_change_mask[i]) begin
          params_next[i*PAR_W +: PAR_W] = table_rd[i*PAR_W +: PAR_W];
          upd_next[i]                   = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      load_reg    <= 1'b1;
      params_reg  <= '0;
      upd_reg     <= '0;
      idx_out_reg <= cps_pkg::CPS_FIRST_SET;
    end else begin
      load_reg    <= load_next;
      params_reg  <= params_next;
      upd_reg     <= upd_next;
      idx_out_reg <= act_idx_reg;
    end
  end

  assign active_set_index = idx_out_reg;
  assign active_params    = params_reg;
  assign param_updated    = upd_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  off_no_auto_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!active_mode && !manual_set_write) |=> $stable(act_idx_reg))
    else $error("Index moved while off");

  clear_cmd_a: assert property (@(posedge sys_clk) disable iff (rst)
    (active_mode && index_clear_command) |=> (evt_cnt_reg == '0 && pend_idx_reg == 4'h1))
    else $error("Clear command did not reset position");

  wrap_last_a: assert property (@(posedge sys_clk) disable iff (rst)
    (active_mode && !clr_evt && !index_clear_command && adv_evt && div_hit
     && pend_idx_reg >= last_set) |=> pend_idx_reg == 4'h1)
    else $error("No wrap after last set");

  range_a: assert property (@(posedge sys_clk) disable iff (rst)
    (active_mode && adv_evt && div_hit && pend_idx_reg < last_set && !clr_evt
     && !index_clear_command) |=> pend_idx_reg == $past(pend_idx_reg) + 4'h1)
    else $error("Index did not step by one");

  divider_a: assert property (@(posedge sys_clk) disable iff (rst)
    (active_mode && adv_evt && !div_hit && !clr_evt && !index_clear_command)
    |=> $stable(pend_idx_reg) && evt_cnt_reg == $past(evt_cnt_reg) + 8'h01)
    else $error("Advanced before divider reached");

  sync_wait_a: assert property (@(posedge sys_clk) disable iff (rst)
    (active_mode && !sync_evt) |=> $stable(act_idx_reg))
    else $error("Set applied without sync point");

  masked_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 (!$past(load_reg)) |-> $stable(params_reg))
    else $error("Parameters changed without switch");

  index_out_a: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 active_set_index == $past(act_idx_reg))
    else $error("Readback index wrong");
endmodule : cps_sequencer

// *** sim/cps_acq_model.sv ***
`timescale 1ns/1ps
// ------------------------------
// Acquisition timing model
// ------------------------------
module cps_acq_model #(
  parameter int LINE_PERIOD = 10,
  parameter int FRAME_LINES = 3
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  output logic      line_start,
  output logic      frame_start
);
  int cyc_reg, cyc_next, line_reg, line_next;

  // Lines spaced apart so an event always lands well before the next sync
  always_comb begin
    cyc_next  = (cyc_reg == LINE_PERIOD - 1) ? 0 : cyc_reg + 1;
    line_next = line_reg;
    if (cyc_reg == LINE_PERIOD - 1) begin
      line_next = (line_reg == FRAME_LINES - 1) ? 0 : line_reg + 1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cyc_reg  <= 0;
      line_reg <= 0;
    end else begin
      cyc_reg  <= cyc_next;
      line_reg <= line_next;
    end
  end

  assign line_start  = !rst && cyc_reg == 0;
  assign frame_start = line_start && line_reg == 0;
endmodule : cps_acq_model

// *** sim/cps_sequencer_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD %0t got %0h want %0h", $time, (a), (b)); end end
module cps_sequencer_tb_top;
  localparam int NP = cps_pkg::CPS_NPAR;
  localparam int PW = NP * cps_pkg::CPS_PAR_W;
  logic                     sys_clk = 1'b0;
  logic                     rst = 1'b1;
  cps_pkg::cps_cfg_s        cfg;
  cps_pkg::cps_events_s     events = '0;
  logic                     index_clear_command = 1'b0;
  logic                     manual_set_write = 1'b0;
  logic [3:0]               manual_set_index = 4'h0;
  logic [NP-1:0]            param_change_mask = '0;
  logic                     set_table_write = 1'b0;
  logic [3:0]               set_table_addr = 4'h0;
  logic [PW-1:0]            set_table_data = '0;
  logic                     line_start, frame_start;
  logic [3:0]               active_set_index, last_idx, cur;
  logic [PW-1:0]            active_params, exp_par;
  logic [NP-1:0]            param_updated;
  logic [1:0]               sync_hist;
  logic                     sync_now;
  logic [3:0]               want_idx;
  logic [NP+PW-1:0]         want_par;
  logic [PW-1:0]            tbl [16];
  logic [3:0]               idx_q [$];
  logic [NP+PW-1:0]         par_q [$];
  int                       num_errors = 0;
  int                       check_count = 0;
  int                       cycles = 0;

  always #25 sys_clk = ~sys_clk;

  cps_sequencer dut (.sys_clk(sys_clk), .rst(rst), .cfg(cfg), .events(events),
    .index_clear_command(index_clear_command), .manual_set_write(manual_set_write),
    .manual_set_index(manual_set_index), .param_change_mask(param_change_mask),
    .set_table_write(set_table_write), .set_table_addr(set_table_addr),
    .set_table_data(set_table_data), .line_start(line_start), .frame_start(frame_start),
    .active_set_index(active_set_index), .active_params(active_params),
    .param_updated(param_updated));

  cps_acq_model far (.sys_clk(sys_clk), .rst(rst), .line_start(line_start),
    .frame_start(frame_start));

  // ------------------------------
  // Output watcher
  // ------------------------------
  assign sync_now = (cfg.apply_sync_point == cps_pkg::CPS_SYNC_FRAME) ? frame_start
                                                                      : line_start;

  // Sampled mid-cycle so outputs have settled; empty queue gives zero
  always @(negedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      summarize();
    end
    if (rst) begin
      last_idx  <= cps_pkg::CPS_FIRST_SET;
      sync_hist <= 2'h0;
    end else begin
      sync_hist <= {sync_hist[0], sync_now};
      if (active_set_index !== last_idx) begin
        last_idx <= active_set_index;
        want_idx = (idx_q.size() > 0) ? idx_q.pop_front() : 4'h0;
        `CHK(active_set_index, want_idx)
        // Readback lags the internal switch by one cycle, sync by two samples
        if (cfg.sequencer_mode_select == cps_pkg::CPS_MODE_ACTIVE) begin
          `CHK(sync_hist[1], 1'b1)
        end
      end
      if (param_updated !== '0) begin
        want_par = (par_q.size() > 0) ? par_q.pop_front() : '0;
        `CHK({param_updated, active_params}, want_par)
      end
    end
  end

  task summarize;
    if (num_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  task tick;
    @(posedge sys_clk);
    #2;
  endtask : tick

  task wait_sync(input bit frame);
    do @(posedge sys_clk); while ((frame ? frame_start : line_start) !== 1'b1);
    #2;
  endtask : wait_sync

  task pulse(input int b, input int n);
    repeat (n) begin
      events = cps_pkg::cps_events_s'(12'h001 << b);
      tick();
      events = '0;
      tick();
    end
  endtask : pulse

  task expect_set(input logic [3:0] k);
    if (k !== cur) begin
      idx_q.push_back(k);
      for (int i = 0; i < NP; i++) begin
        if (param_change_mask[i]) exp_par[i*32 +: 32] = tbl[k][i*32 +: 32];
      end
      par_q.push_back({param_change_mask, exp_par});
    end
    cur = k;
  endtask : expect_set

  task step(input int b, input int n, input bit adv);
    wait_sync(1'b0);
    pulse(b, n);
    if (adv) expect_set((cur == cfg.set_count) ? 4'h1 : cur + 4'h1);
    wait_sync(cfg.apply_sync_point == cps_pkg::CPS_SYNC_FRAME);
    repeat (4) tick();
  endtask : step

  // Negative bit selects the software clear command
  task clear_by(input int b);
    wait_sync(1'b0);
    if (b < 0) begin
      index_clear_command = 1'b1;
      tick();
      index_clear_command = 1'b0;
    end else pulse(b, 1);
    expect_set(4'h1);
    wait_sync(1'b0);
    repeat (4) tick();
  endtask : clear_by

  task manual(input logic [3:0] k);
    expect_set(k);
    manual_set_index = k;
    manual_set_write = 1'b1;
    tick();
    manual_set_write = 1'b0;
    wait_sync(1'b0);
    repeat (4) tick();
  endtask : manual

  initial begin
    int seed_v;
    seed_v = $urandom(17914);
    cfg = '0;
    cfg.set_count = 4'h3;
    cfg.advance_event_divider = 8'h01;
    cur = cps_pkg::CPS_FIRST_SET;
    exp_par = '0;
    repeat (5) tick();
    rst = 1'b0;
    tick();
    `CHK(active_set_index, cps_pkg::CPS_FIRST_SET)
    set_table_write = 1'b1;
    for (int k = 1; k <= 4; k++) begin
      tbl[k] = {$urandom, $urandom, $urandom, $urandom};
      set_table_addr = 4'(k);
      set_table_data = tbl[k];
      tick();
    end
    set_table_write = 1'b0;
    param_change_mask = 4'($urandom_range(15, 1));
    cfg.sequencer_mode_select = cps_pkg::CPS_MODE_ACTIVE;
    for (int s = 1; s <= 12; s++) begin
      cfg.advance_source_select = cps_pkg::cps_src_e'(s);
      step(12 - s, 1, 1'b1);
    end
    step(11, 1, 1'b0);
    cfg.set_count = 4'h4;
    cfg.advance_source_select = cps_pkg::CPS_SRC_IN2;
    cfg.advance_event_divider = 8'h03;
    step(10, 2, 1'b0);
    step(10, 1, 1'b1);
    cfg.advance_event_divider = 8'h02;
    step(10, 1, 1'b0);
    clear_by(-1);
    step(10, 1, 1'b0);
    step(10, 1, 1'b1);
    cfg.index_clear_source = cps_pkg::CPS_SRC_CNT1;
    clear_by(7);
    cfg.index_clear_source = cps_pkg::CPS_SRC_NONE;
    cfg.advance_event_divider = 8'h01;
    cfg.apply_sync_point = cps_pkg::CPS_SYNC_FRAME;
    step(10, 1, 1'b1);
    step(10, 1, 1'b1);
    cfg.apply_sync_point = cps_pkg::CPS_SYNC_LINE;
    cfg.sequencer_mode_select = cps_pkg::CPS_MODE_OFF;
    step(10, 1, 1'b0);
    manual(4'h4);
    cfg.sequencer_mode_select = cps_pkg::CPS_MODE_ACTIVE;
    cfg.advance_source_select = cps_pkg::CPS_SRC_NONE;
    step(10, 1, 1'b0);
    manual(4'h2);
    repeat (10) tick();
    `CHK(idx_q.size() + par_q.size(), 0)
    summarize();
  end
endmodule : cps_sequencer_tb_top
